// [timer16_waveform_mode_control_test.sv]
`include "tmw_regs.svh"
`define CHK(nm, ex, got) begin num_checks++; if ((got) !== (ex)) begin n_mismatch++; \
    $display("BAD %s exp %h got %h", nm, ex, got); end end

module timer16_waveform_mode_control_test;
    timeunit 1ns;
    timeprecision 1ps;
    logic ref_clk, reset, psel, penable, pwrite, count_tick, pin_dir, pin, cap;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, q;
    logic pready, pslverr, e, wa, wb, wc, oa, ob, oc, cc, ovf;
    int n_mismatch = 0;
    int num_checks = 0;
    typedef struct packed {logic [7:0] a; logic [7:0] b; logic [2:0] ov; logic cc;} tmw_row_t;
    // control a, control b, expected takeover a/b/c, capture pin connected
    tmw_row_t rows [8] = '{'{8'h54, 8'h00, 3'b111, 1'b1}, '{8'h55, 8'h08, 3'b000, 1'b1},
        '{8'h56, 8'h18, 3'b100, 1'b0}, '{8'h57, 8'h18, 3'b100, 1'b1},
        '{8'h55, 8'h10, 3'b100, 1'b1}, '{8'h55, 8'h00, 3'b000, 1'b1},
        '{8'ha8, 8'h10, 3'b111, 1'b0}, '{8'h2c, 8'h18, 3'b011, 1'b0}};
    logic [7:0] acts [3] = '{8'hfc, 8'ha8, 8'h54};
    logic [2:0] outs [3] = '{3'b111, 3'b000, 3'b111};

    tmw_wave_ctrl dut (.ref_clk(ref_clk), .reset(reset), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .count_tick(count_tick), .capture_input_pin(cap),
        .chan_a_wave_out(wa), .chan_b_wave_out(wb), .chan_c_wave_out(wc),
        .chan_a_pin_override(oa), .chan_b_pin_override(ob), .chan_c_pin_override(oc),
        .capture_pin_connected(cc), .overflow_flag(ovf));
    tmw_pin_load load_a (.pin_dir(pin_dir), .port_data(1'b1), .override(oa), .wave(wa),
        .pin_level(pin));

    initial
    begin
        ref_clk = 1'b0;
        forever #4 ref_clk = ~ref_clk;
    end

    // ----------------------------------------
    // bus and timer helpers
    // ----------------------------------------
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        @(posedge ref_clk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge ref_clk);
        penable <= 1'b1;
        // request held until pready is sampled high; a dead slave is left to the watchdog
        do
        begin
            @(posedge ref_clk);
        end
        while (pready !== 1'b1);
        q = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic tick(input int n);
        repeat (n)
        begin
            @(posedge ref_clk);
            count_tick <= 1'b1;
            @(posedge ref_clk);
            count_tick <= 1'b0;
        end
        repeat (2) @(posedge ref_clk);
    endtask

    task automatic stop_test;
        $display("checks %0d mismatches %0d", num_checks, n_mismatch);
        if (n_mismatch == 0 && num_checks > 0)
        begin
            $display("verification passed");
        end
        else
        begin
            $display("verification failed");
        end
        $finish;
    endtask

    initial
    begin
        #200000;
        n_mismatch++;
        stop_test;
    end

    // ----------------------------------------
    // main sequence
    // ----------------------------------------
    initial
    begin
        reset = 1'b1;
        {psel, penable, pwrite, count_tick, pin_dir, cap} = 6'h00;
        paddr = 12'h000;
        pwdata = 32'h0;
        repeat (12) @(posedge ref_clk);
        reset <= 1'b0;
        @(posedge ref_clk);
        `CHK("reset outs", 8'h01, {wa, wb, wc, oa, ob, oc, ovf, cc})
        `CHK("pin undriven", 1'b1, pin)
        apb(0, `TMW_OFF_CTRL_A, 0);
        `CHK("ctrl_a reset", 32'h0, q)
        foreach (rows[i])
        begin
            apb(1, `TMW_OFF_CTRL_B, {24'h0, rows[i].b});
            apb(1, `TMW_OFF_CTRL_A, {24'h0, rows[i].a});
            repeat (2) @(posedge ref_clk);
            `CHK("override", rows[i].ov, {oa, ob, oc})
            `CHK("capture conn", rows[i].cc, cc)
            apb(0, `TMW_OFF_CTRL_A, 0);
            `CHK("ctrl_a", {24'h0, rows[i].a}, q)
            apb(0, `TMW_OFF_CTRL_B, 0);
            `CHK("ctrl_b", {24'h0, rows[i].b}, q)
        end
        // non-pwm set, clear, toggle with compare 2 from counter 0
        apb(1, `TMW_OFF_CTRL_B, 0);
        for (int k = 0; k < 3; k++)
        begin
            apb(1, `TMW_OFF_CMP_A + 12'(4 * k), 2);
        end
        for (int k = 0; k < 3; k++)
        begin
            apb(1, `TMW_OFF_CTRL_A, {24'h0, acts[k]});
            apb(1, `TMW_OFF_COUNT, 0);
            tick(4);
            `CHK("non-pwm", outs[k], {wa, wb, wc})
        end
        // fast pwm 8-bit: set at top, clear on match
        apb(1, `TMW_OFF_CTRL_B, 8'h08);
        // mode 5: a clears on match, b sets on match and clears at top
        apb(1, `TMW_OFF_CTRL_A, 8'hb1);
        apb(1, `TMW_OFF_COUNT, 16'hfe);
        tick(3);
        `CHK("fast top", 1'b1, wa)
        `CHK("fast ovf", 1'b1, ovf)
        pin_dir <= 1'b1;
        tick(4);
        `CHK("fast match", 1'b0, wa)
        `CHK("pin driven", 1'b0, pin)
        // compares moved to top: second pass over top has match and top together
        apb(1, `TMW_OFF_CMP_A, 16'hff);
        apb(1, `TMW_OFF_CMP_B, 16'hff);
        tick(510);
        `CHK("cmp at top", 1'b1, wa)
        `CHK("cmp b at top", 1'b0, wb)
        // phase correct 8-bit, compare loaded while in normal mode
        apb(1, `TMW_OFF_CTRL_B, 0);
        apb(1, `TMW_OFF_CTRL_A, 0);
        apb(1, `TMW_OFF_STATUS, 1);
        apb(1, `TMW_OFF_CMP_A, 16'h80);
        apb(1, `TMW_OFF_COUNT, 0);
        apb(1, `TMW_OFF_CTRL_A, 8'h89);
        tick(16'h90);
        `CHK("pc up", 1'b0, wa)
        tick(256);
        `CHK("pc down", 1'b1, wa)
        `CHK("pc no ovf", 1'b0, ovf)
        tick(128);
        `CHK("pc bottom", 1'b1, ovf)
        // clear on match with top from compare a: wraps to bottom after top
        apb(1, `TMW_OFF_CTRL_B, 8'h08);
        apb(1, `TMW_OFF_CTRL_A, 0);
        apb(1, `TMW_OFF_COUNT, 0);
        tick(16'h82);
        apb(0, `TMW_OFF_COUNT, 0);
        `CHK("ctc wrap", 32'h1, q)
        // capture pin: taken while enabled, ignored once capture is top
        cap <= 1'b1;
        repeat (4) @(posedge ref_clk);
        apb(0, `TMW_OFF_CAPT, 0);
        `CHK("capture", 32'h1, q)
        apb(1, `TMW_OFF_COUNT, 5);
        cap <= 1'b0;
        apb(1, `TMW_OFF_CTRL_B, 8'h18);
        cap <= 1'b1;
        repeat (4) @(posedge ref_clk);
        apb(0, `TMW_OFF_CAPT, 0);
        `CHK("capture off", 32'h1, q)
        // mode 9: top from compare a, overflow only back at bottom
        apb(1, `TMW_OFF_CTRL_B, 8'h10);
        apb(1, `TMW_OFF_CTRL_A, 8'h01);
        apb(1, `TMW_OFF_STATUS, 1);
        apb(1, `TMW_OFF_COUNT, 0);
        tick(256);
        `CHK("pfc no ovf", 1'b0, ovf)
        tick(1);
        `CHK("pfc bottom", 1'b1, ovf)
        // reset in mid-run brings every output back to its idle level
        reset <= 1'b1;
        repeat (2) @(posedge ref_clk);
        reset <= 1'b0;
        @(posedge ref_clk);
        `CHK("re-reset outs", 8'h01, {wa, wb, wc, oa, ob, oc, ovf, cc})
        apb(0, 12'h020, 0);
        `CHK("unmapped", 33'h100000000, {e, q})
        stop_test;
    end
endmodule // timer16_waveform_mode_control_test

// [tmw_chan_out.sv]
// one compare channel: next output level and pin takeover
module tmw_chan_out
(
    input tmw_pkg::tmw_wave_class_t wave_class,
    input logic [3:0] wave_mode_sel,
    input logic [1:0] out_mode,
    input logic is_chan_a,
    input logic tick,
    input logic match,
    input logic at_top,
    input logic count_up,
    input logic wave_cur,
    output logic wave_nxt,
    output logic connected
);
    import tmw_pkg::*;

    logic toggle_ok;

    // ----------------------------------------------------------------
    // toggle mode exists on every channel in non-pwm modes, but in pwm modes only on channel a in a few modes
    // ----------------------------------------------------------------
    always_comb
    begin
        toggle_ok = 1'b1;
        if (wave_class == TMW_WC_FAST)
        begin
            toggle_ok = is_chan_a && (wave_mode_sel[3:1] == 3'h7);
        end
        else if (wave_class == TMW_WC_PC || wave_class == TMW_WC_PFC)
        begin
            toggle_ok = is_chan_a && (wave_mode_sel[3:2] == 2'h2);
        end
    end

    // takeover whenever a mode bit is set, unless toggle is not offered here
    assign connected = (out_mode != TMW_OM_OFF) && ((out_mode != TMW_OM_TOGGLE) || toggle_ok);

    // ----------------------------------------------------------------
    // set / clear / toggle actions per waveform family
    // ----------------------------------------------------------------
    always_comb
    begin
        wave_nxt = wave_cur;
        if (tick && connected)
        begin
            case (wave_class)
                TMW_WC_FAST:
                begin
                    if (out_mode[1])
                    begin
                        // top action wins, so a match equal to top is ignored
                        if (at_top)
                            wave_nxt = ~out_mode[0];
                        else if (match)
                            wave_nxt = out_mode[0];
                    end
                    else if (match)
                        wave_nxt = ~wave_cur;
                end
                TMW_WC_PC, TMW_WC_PFC:
                begin
                    if (out_mode[1] && match)
                        wave_nxt = count_up ? out_mode[0] : ~out_mode[0];
                    else if (match)
                        wave_nxt = ~wave_cur;
                end
                default:
                begin
                    if (match)
                    begin
                        case (out_mode)
                            TMW_OM_TOGGLE: wave_nxt = ~wave_cur;
                            TMW_OM_CLEAR: wave_nxt = 1'b0;
                            TMW_OM_SET: wave_nxt = 1'b1;
                            default: wave_nxt = wave_cur;
                        endcase
                    end
                end
            endcase
        end
    end

endmodule // tmw_chan_out

// [tmw_pin_load.sv]
// ----------------------------------------
// port pin with its external load
// ----------------------------------------
module tmw_pin_load
(
    input wire logic pin_dir,
    input wire logic port_data,
    input wire logic override,
    input wire logic wave,
    output logic pin_level
);
    timeunit 1ns;
    timeprecision 1ps;
    // an undriven pin floats to the pull-up, so a missing direction bit shows as high
    assign pin_level = !pin_dir ? 1'b1 : (override ? wave : port_data);
endmodule // tmw_pin_load

// [tmw_pkg.sv]
package tmw_pkg;

    // counting family decoded from the waveform mode selector
    typedef enum logic [4:0]
    {
        TMW_WC_NORMAL = 5'b00001,
        TMW_WC_CTC = 5'b00010,
        TMW_WC_FAST = 5'b00100,
        TMW_WC_PC = 5'b01000,
        TMW_WC_PFC = 5'b10000
    } tmw_wave_class_t;

    typedef enum logic [1:0]
    {
        TMW_OM_OFF = 2'h0,
        TMW_OM_TOGGLE = 2'h1,
        TMW_OM_CLEAR = 2'h2,
        TMW_OM_SET = 2'h3
    } tmw_out_mode_t;

    typedef logic [15:0] tmw_word_t;

    typedef struct packed {
        logic [7:0] ctrl_a;
        logic [1:0] wgm_high;
        tmw_word_t cnt;
        logic cnt_up;
        tmw_word_t [2:0] cmp_buf;
        tmw_word_t [2:0] cmp_act;
        tmw_word_t capt;
        logic ovf_flag;
        logic [2:0] match_flag;
        logic capt_flag;
        logic blk_match;
        logic [2:0] wave;
        logic [2:0] override;
        logic capt_pin_en;
        logic capt_s1;
        logic capt_s2;
        logic capt_prev;
        logic pready;
        logic [31:0] prdata;
        logic pslverr;
    } tmw_state_t;

endpackage

// [tmw_regs.svh]
`ifndef TMW_REGS_SVH
`define TMW_REGS_SVH

// ----------------------------------------------------------------
// register byte offsets
// ----------------------------------------------------------------
`define TMW_OFF_CTRL_A 12'h000
`define TMW_OFF_CTRL_B 12'h004
`define TMW_OFF_COUNT 12'h008
`define TMW_OFF_CMP_A 12'h00c
`define TMW_OFF_CMP_B 12'h010
`define TMW_OFF_CMP_C 12'h014
`define TMW_OFF_CAPT 12'h018
`define TMW_OFF_STATUS 12'h01c

// ----------------------------------------------------------------
// field positions
// ----------------------------------------------------------------
`define TMW_CA_OM_A_POS 6
`define TMW_CA_WGM_LO_POS 0
`define TMW_CB_WGM_HI_POS 3
`define TMW_ST_OVF_BIT 0
`define TMW_ST_MATCH_POS 1
`define TMW_ST_CAPT_BIT 4
`define TMW_ST_DIR_BIT 5

// ----------------------------------------------------------------
// reset values and fixed counts
// ----------------------------------------------------------------
`define TMW_CTRL_RST 8'h00
`define TMW_WORD_RST 16'h0000
`define TMW_TOP_MAX 16'hffff
`define TMW_TOP_8BIT 16'h00ff
`define TMW_TOP_9BIT 16'h01ff
`define TMW_TOP_10BIT 16'h03ff
`define TMW_BOTTOM 16'h0000

`endif

// [tmw_wave_ctrl.sv]
// Functional notes
// - control a: modes a,b,c high bits, selector low
// - nonzero output mode takes over the pin, except toggle where not offered
// - non-pwm: off, toggle, clear, set on match
// - fast pwm: clear/set on match, reverse at top
// - fast toggle only channel a, modes 14-15
// - fast: match equal top ignored, top acts
// - dual slope: action flips with count direction
// - dual slope toggle only channel a, modes 8-11
// - four-bit selector picks sequence, top, type
// - modes 0,4,12: immediate update, overflow at max
// - phase correct tops; update top, overflow bottom
// - fast pwm tops; update and overflow at top
// - modes 8,9: update and overflow at bottom
// - selector high bits in control b 4:3
// - capture-defined top disconnects capture pin
//
// Added by the designer: the APB register port and the register offsets.
`include "tmw_regs.svh"

module tmw_wave_ctrl
#(
    parameter int ADDR_W = 12
)
(
    input wire logic ref_clk,
    input wire logic reset,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [ADDR_W-1:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic count_tick,
    input wire logic capture_input_pin,
    output logic chan_a_wave_out,
    output logic chan_b_wave_out,
    output logic chan_c_wave_out,
    output logic chan_a_pin_override,
    output logic chan_b_pin_override,
    output logic chan_c_pin_override,
    output logic capture_pin_connected,
    output logic overflow_flag
);
    import tmw_pkg::*;

    tmw_state_t st_r;
    tmw_state_t st_nxt;
    logic [3:0] wave_mode_sel;
    tmw_wave_class_t wclass;
    tmw_word_t top;
    logic at_top;
    logic at_bottom;
    logic capt_top;
    logic [2:0] match;
    logic [2:0] wave_nxt;
    logic [2:0] conn;
    logic apb_first;
    logic apb_done;
    logic [11:0] addr;

    // ----------------------------------------------------------------
    // waveform mode decode
    // ----------------------------------------------------------------
    // decoded from stored bits, so a write acts from the next tick on
    assign wave_mode_sel = {st_r.wgm_high, st_r.ctrl_a[`TMW_CA_WGM_LO_POS +: 2]};
    assign capt_top = wave_mode_sel[3] && !wave_mode_sel[0];

    always_comb
    begin
        case (wave_mode_sel)
            4'h4, 4'hc: wclass = TMW_WC_CTC;
            4'h5, 4'h6, 4'h7, 4'he, 4'hf: wclass = TMW_WC_FAST;
            4'h1, 4'h2, 4'h3, 4'ha, 4'hb: wclass = TMW_WC_PC;
            4'h8, 4'h9: wclass = TMW_WC_PFC;
            default: wclass = TMW_WC_NORMAL; // reserved 13 counts like normal
        endcase
    end

    // top source per mode
    always_comb
    begin
        case (wave_mode_sel)
            4'h1, 4'h5: top = `TMW_TOP_8BIT;
            4'h2, 4'h6: top = `TMW_TOP_9BIT;
            4'h3, 4'h7: top = `TMW_TOP_10BIT;
            4'h4, 4'h9, 4'hb, 4'hf: top = st_r.cmp_act[0];
            4'h8, 4'ha, 4'hc, 4'he: top = st_r.capt;
            default: top = `TMW_TOP_MAX;
        endcase
    end

    assign at_top = (st_r.cnt == top);
    assign at_bottom = (st_r.cnt == `TMW_BOTTOM);

    // ----------------------------------------------------------------
    // compare channels
    // ----------------------------------------------------------------
    generate
        for (genvar gi = 0; gi < 3; gi++)
        begin : g_chan
            localparam int OM_POS = `TMW_CA_OM_A_POS - 2 * gi;
            // a counter write blocks the next tick's match on all channels
            assign match[gi] = count_tick && !st_r.blk_match && (st_r.cnt == st_r.cmp_act[gi]);
            tmw_chan_out u_chan
            (
                .wave_class(wclass),
                .wave_mode_sel(wave_mode_sel),
                .out_mode(st_r.ctrl_a[OM_POS +: 2]),
                .is_chan_a(gi == 0),
                .tick(count_tick),
                .match(match[gi]),
                .at_top(at_top),
                .count_up(st_r.cnt_up),
                .wave_cur(st_r.wave[gi]),
                .wave_nxt(wave_nxt[gi]),
                .connected(conn[gi])
            );
        end
    endgenerate

    // ----------------------------------------------------------------
    // apb slave: one wait state, answer registered
    // ----------------------------------------------------------------
    assign apb_first = psel && penable && !st_r.pready;
    assign apb_done = psel && penable && st_r.pready;
    assign addr = paddr[11:0];

    always_comb
    begin
        st_nxt = st_r;
        st_nxt.pready = apb_first;
        st_nxt.pslverr = 1'b0;

        // read path, loaded in the first access cycle
        if (apb_first)
        begin
            st_nxt.prdata = 32'h0000_0000;
            if (addr == `TMW_OFF_CTRL_A)
                st_nxt.prdata[7:0] = st_r.ctrl_a;
            else if (addr == `TMW_OFF_CTRL_B)
                st_nxt.prdata[`TMW_CB_WGM_HI_POS +: 2] = st_r.wgm_high;
            else if (addr == `TMW_OFF_COUNT)
                st_nxt.prdata[15:0] = st_r.cnt;
            else if (addr == `TMW_OFF_CMP_A)
                st_nxt.prdata[15:0] = st_r.cmp_buf[0];
            else if (addr == `TMW_OFF_CMP_B)
                st_nxt.prdata[15:0] = st_r.cmp_buf[1];
            else if (addr == `TMW_OFF_CMP_C)
                st_nxt.prdata[15:0] = st_r.cmp_buf[2];
            else if (addr == `TMW_OFF_CAPT)
                st_nxt.prdata[15:0] = st_r.capt;
            else if (addr == `TMW_OFF_STATUS)
            begin
                st_nxt.prdata[`TMW_ST_OVF_BIT] = st_r.ovf_flag;
                st_nxt.prdata[`TMW_ST_MATCH_POS +: 3] = st_r.match_flag;
                st_nxt.prdata[`TMW_ST_CAPT_BIT] = st_r.capt_flag;
                st_nxt.prdata[`TMW_ST_DIR_BIT] = st_r.cnt_up;
            end
            else
                st_nxt.pslverr = 1'b1;
        end

        // clear on the tick after a counter write
        if (count_tick)
            st_nxt.blk_match = 1'b0;

        // ------------------------------------------------------------
        // counting sequence
        // ------------------------------------------------------------
        if (count_tick)
        begin
            if (wclass == TMW_WC_PC || wclass == TMW_WC_PFC)
            begin
                if (st_r.cnt_up)
                begin
                    if (st_r.cnt >= top)
                    begin
                        st_nxt.cnt_up = 1'b0;
                        st_nxt.cnt = at_bottom ? st_r.cnt : st_r.cnt - 16'h0001;
                    end
                    else
                        st_nxt.cnt = st_r.cnt + 16'h0001;
                end
                else if (at_bottom)
                begin
                    st_nxt.cnt_up = 1'b1;
                    st_nxt.cnt = st_r.cnt + 16'h0001;
                end
                else
                    st_nxt.cnt = st_r.cnt - 16'h0001;
            end
            else
            begin
                // ctc with top below the count runs on to max and wraps
                st_nxt.cnt_up = 1'b1;
                st_nxt.cnt = (at_top || st_r.cnt == `TMW_TOP_MAX) ? `TMW_BOTTOM
                                                                   : st_r.cnt + 16'h0001;
            end
        end

        // ------------------------------------------------------------
        // compare buffer transfer points
        // ------------------------------------------------------------
        if (wclass == TMW_WC_NORMAL || wclass == TMW_WC_CTC)
            st_nxt.cmp_act = st_r.cmp_buf;
        else if (wclass == TMW_WC_PFC && count_tick && at_bottom)
            st_nxt.cmp_act = st_r.cmp_buf;
        else if (wclass != TMW_WC_PFC && count_tick && at_top)
            st_nxt.cmp_act = st_r.cmp_buf;

        // ------------------------------------------------------------
        // register writes; flag clears before sets so events win
        // ------------------------------------------------------------
        if (apb_done && pwrite)
        begin
            if (addr == `TMW_OFF_CTRL_A)
                st_nxt.ctrl_a = pwdata[7:0];
            else if (addr == `TMW_OFF_CTRL_B)
                st_nxt.wgm_high = pwdata[`TMW_CB_WGM_HI_POS +: 2];
            else if (addr == `TMW_OFF_COUNT)
            begin
                st_nxt.cnt = pwdata[15:0];
                st_nxt.blk_match = 1'b1;
            end
            else if (addr == `TMW_OFF_CMP_A)
                st_nxt.cmp_buf[0] = pwdata[15:0];
            else if (addr == `TMW_OFF_CMP_B)
                st_nxt.cmp_buf[1] = pwdata[15:0];
            else if (addr == `TMW_OFF_CMP_C)
                st_nxt.cmp_buf[2] = pwdata[15:0];
            else if (addr == `TMW_OFF_CAPT)
                st_nxt.capt = pwdata[15:0];
            else if (addr == `TMW_OFF_STATUS)
            begin
                st_nxt.ovf_flag = st_r.ovf_flag & ~pwdata[`TMW_ST_OVF_BIT];
                st_nxt.match_flag = st_r.match_flag & ~pwdata[`TMW_ST_MATCH_POS +: 3];
                st_nxt.capt_flag = st_r.capt_flag & ~pwdata[`TMW_ST_CAPT_BIT];
            end
        end

        // ------------------------------------------------------------
        // overflow flag per family
        // ------------------------------------------------------------
        if (count_tick)
        begin
            if ((wclass == TMW_WC_NORMAL || wclass == TMW_WC_CTC) && st_r.cnt == `TMW_TOP_MAX)
                st_nxt.ovf_flag = 1'b1;
            else if (wclass == TMW_WC_FAST && at_top)
                st_nxt.ovf_flag = 1'b1;
            else if ((wclass == TMW_WC_PC || wclass == TMW_WC_PFC) && at_bottom && !st_r.cnt_up)
                st_nxt.ovf_flag = 1'b1;
        end
        st_nxt.match_flag = st_nxt.match_flag | match;

        // ------------------------------------------------------------
        // capture pin: two-stage sync, rising edge, off when it is top
        // ------------------------------------------------------------
        st_nxt.capt_s1 = capture_input_pin;
        st_nxt.capt_s2 = st_r.capt_s1;
        st_nxt.capt_prev = st_r.capt_s2;
        st_nxt.capt_pin_en = !capt_top;
        if (st_r.capt_s2 && !st_r.capt_prev && !capt_top)
        begin
            st_nxt.capt = st_r.cnt;
            st_nxt.capt_flag = 1'b1;
        end

        // outputs and pin takeover
        st_nxt.wave = wave_nxt;
        st_nxt.override = conn;
    end

    // registered state
    always_ff @(posedge ref_clk)
    begin
        if (reset)
        begin
            st_r <= '0;
            st_r.ctrl_a <= `TMW_CTRL_RST;
            st_r.cnt <= `TMW_WORD_RST;
            st_r.cnt_up <= 1'b1;
            st_r.capt_pin_en <= 1'b1;
        end
        else
            st_r <= st_nxt;
    end

    // ----------------------------------------------------------------
    // output wiring
    // ----------------------------------------------------------------
    assign prdata = st_r.prdata;
    assign pready = st_r.pready;
    assign pslverr = st_r.pslverr;
    assign chan_a_wave_out = st_r.wave[0];
    assign chan_b_wave_out = st_r.wave[1];
    assign chan_c_wave_out = st_r.wave[2];
    assign chan_a_pin_override = st_r.override[0];
    assign chan_b_pin_override = st_r.override[1];
    assign chan_c_pin_override = st_r.override[2];
    assign capture_pin_connected = st_r.capt_pin_en;
    assign overflow_flag = st_r.ovf_flag;

    // ----------------------------------------------------------------
    // assertions
    // ----------------------------------------------------------------
    default clocking cb @(posedge ref_clk);
    endclocking
    default disable iff (reset);

    sequence s_ctrl_a_write;
        psel && penable && pready && pwrite && addr == `TMW_OFF_CTRL_A;
    endsequence
    sequence s_fast_top_tick;
        wclass == TMW_WC_FAST && count_tick && at_top;
    endsequence

    property p_ctrl_fields;
        s_ctrl_a_write |=> st_r.ctrl_a == $past(pwdata[7:0]);
    endproperty
    a_ctrl_fields: assert property (p_ctrl_fields) else $error("control a not stored");

    property p_override;
        st_r.ctrl_a[7] [*2] |-> chan_a_pin_override;
    endproperty
    a_override: assert property (p_override) else $error("channel a pin not taken over");

    property p_nonpwm_set;
        (wclass == TMW_WC_NORMAL || wclass == TMW_WC_CTC) && match[0] && st_r.ctrl_a[7:6] == 2'h3
        |=> chan_a_wave_out;
    endproperty
    a_nonpwm_set: assert property (p_nonpwm_set) else $error("set on match failed");

    property p_fast_top;
        s_fast_top_tick ##0 st_r.ctrl_a[7:6] == 2'h2 |=> chan_a_wave_out;
    endproperty
    a_fast_top: assert property (p_fast_top) else $error("fast pwm top not set");

    property p_fast_b_off;
        wclass == TMW_WC_FAST && st_r.ctrl_a[5:4] == 2'h1 |=> $stable(chan_b_wave_out)
        && !chan_b_pin_override;
    endproperty
    a_fast_b_off: assert property (p_fast_b_off) else $error("channel b toggled in fast");

    property p_fast_equal_top;
        s_fast_top_tick ##0 (st_r.cmp_act[1] == top && st_r.ctrl_a[5:4] == 2'h3)
        |=> !chan_b_wave_out;
    endproperty
    a_fast_equal_top: assert property (p_fast_equal_top) else $error("match at top acted");

    property p_dual_down;
        (wclass == TMW_WC_PC || wclass == TMW_WC_PFC) && match[2] && !st_r.cnt_up
        && st_r.ctrl_a[3:2] == 2'h2 |=> chan_c_wave_out;
    endproperty
    a_dual_down: assert property (p_dual_down) else $error("down match did not set");

    property p_ctc_wrap;
        wclass == TMW_WC_CTC && count_tick && at_top && !(apb_done && pwrite) |=> at_bottom;
    endproperty
    a_ctc_wrap: assert property (p_ctc_wrap) else $error("ctc did not clear");

    property p_pc8_turn;
        wave_mode_sel == 4'h1 && count_tick && st_r.cnt_up && st_r.cnt == `TMW_TOP_8BIT
        && !(apb_done && pwrite) |=> st_r.cnt == 16'h00fe && !st_r.cnt_up;
    endproperty
    a_pc8_turn: assert property (p_pc8_turn) else $error("phase correct did not turn");

    property p_fast_tov;
        s_fast_top_tick |=> overflow_flag;
    endproperty
    a_fast_tov: assert property (p_fast_tov) else $error("overflow not set at top");

    property p_pfc_update;
        wclass == TMW_WC_PFC && count_tick && at_bottom |=> st_r.cmp_act == $past(st_r.cmp_buf);
    endproperty
    a_pfc_update: assert property (p_pfc_update) else $error("buffer not moved at bottom");

    property p_capt_off;
        capt_top [*2] |-> !capture_pin_connected;
    endproperty
    a_capt_off: assert property (p_capt_off) else $error("capture pin still connected");

endmodule // tmw_wave_ctrl
